// >>> pss_scan_seq.sv
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_scan_seq
    import pss_pkg::*;
#(
    parameter int WDOG_CYC = `PSS_WDOG_CYC
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [15:0] i_in_pins,
    output logic [15:0] o_out_pins,
    input wire logic i_frc_req,
    input wire logic [1:0] i_frc_class,
    input wire logic [3:0] i_frc_pt,
    input wire logic i_frc_val,
    input wire logic i_prog_done,
    input wire logic i_prog_wr,
    input wire logic [1:0] i_prog_class,
    input wire logic [3:0] i_prog_pt,
    input wire logic i_prog_val,
    input wire logic i_imm_out,
    input wire logic [3:0] i_imm_pt,
    input wire logic [3:0] i_imm_in_pt,
    output logic o_imm_in_val,
    input wire logic [3:0] i_in_pt,
    output logic o_in_val,
    input wire logic i_bus_req,
    input wire logic i_bus_local,
    output logic o_bus_grant,
    output logic o_spec_strobe,
    output logic [15:0] o_spec_data,
    output logic o_clk_refresh,
    output logic o_fatal_err,
    output logic [3:0] o_segment,
    output logic [7:0] o_loop_run,
    output logic o_solve_en
);
    typedef struct packed {
        pss_seg_t seg;
        logic run;
        logic fatal;
        logic [15:0] err;
        logic [15:0] in_img;
        logic [15:0] out_img;
        logic [15:0] oth_img;
        logic [15:0] pins;
        logic [47:0] ov_en;
        logic [47:0] ov_held;
        logic [15:0] frc_mask;
        logic [31:0] wdog_lim;
        logic [31:0] solve_cnt;
        logic [31:0] scan_cnt;
        logic [31:0] scur;
        logic [31:0] smin;
        logic [31:0] smax;
        logic [31:0] rtc;
        logic [7:0] loop_en;
        logic [7:0] loop_iv;
        logic [15:0] filt;
        logic [3:0] fast_byp;
        logic loop_started;
        logic spec;
        logic clkr;
        logic [31:0] rdata;
    } pss_state_t;
    pss_state_t st_q, st_d;
    logic [15:0] filt_in;
    logic loop_busy;
    logic [7:0] loop_run;
    logic [1:0] in_sync0_q [16];
    logic [15:0] live_q1, live_q2;

    function automatic logic [5:0] pt_idx(input logic [1:0] cls, input logic [3:0] pt);
        pt_idx = {cls, pt};
    endfunction

    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_in
            pss_in_filter u_filt (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_raw(i_in_pins[g]),
                .i_bypass(g < `PSS_NFAST ? st_q.fast_byp[g % 4] : 1'b0),
                .i_len(st_q.filt),
                .o_val(filt_in[g])
            );
        end
    endgenerate

    // separate two-stage sync for the immediate-read live path
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            live_q1 <= 16'h0000;
            live_q2 <= 16'h0000;
        end else begin
            live_q1 <= i_in_pins;
            live_q2 <= live_q1;
        end
    end

    pss_loop_sched u_loops (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_start(st_q.seg == SEG_LOOP && !st_q.loop_started),
        .i_loop_en(st_q.loop_en),
        .i_interval(st_q.loop_iv),
        .o_busy(loop_busy),
        .o_loop_run(loop_run)
    );

    always_comb begin
        st_d = st_q;
        st_d.spec = 1'b0;
        st_d.clkr = 1'b0;
        st_d.rdata = 32'h0000_0000;
        st_d.scan_cnt = st_q.scan_cnt + 32'h0000_0001;
        // register writes
        if (i_wr) begin
            case (i_addr)
                `PSS_ADDR_CTRL: begin
                    st_d.run = i_wdata[`PSS_CTRL_RUN] & ~st_q.fatal;
                    if (i_wdata[`PSS_STAT_FATAL]) begin
                        st_d.fatal = 1'b0;
                    end
                end
                `PSS_ADDR_WDOG: st_d.wdog_lim = i_wdata;
                `PSS_ADDR_ERR: st_d.err = 16'h0000;
                `PSS_ADDR_OVEN: begin
                    st_d.ov_en[i_wdata[21:16]] = i_wdata[0];
                    st_d.ov_held[i_wdata[21:16]] = i_wdata[0] ? st_q.ov_held[i_wdata[21:16]] : 1'b0;
                end
                `PSS_ADDR_LOOPEN: st_d.loop_en = i_wdata[7:0];
                `PSS_ADDR_LOOPIV: st_d.loop_iv = i_wdata[7:0];
                `PSS_ADDR_RTC: st_d.rtc = i_wdata;
                `PSS_ADDR_FILT: begin
                    st_d.filt = i_wdata[15:0];
                    st_d.fast_byp = i_wdata[19:16];
                end
                default: ;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                `PSS_ADDR_CTRL: st_d.rdata = {31'h0000_0000, st_q.run};
                `PSS_ADDR_STAT: st_d.rdata = {23'h00_0000, st_q.seg, 3'h0, st_q.fatal, st_q.run};
                `PSS_ADDR_WDOG: st_d.rdata = st_q.wdog_lim;
                `PSS_ADDR_SCUR: st_d.rdata = st_q.scur;
                `PSS_ADDR_SMIN: st_d.rdata = st_q.smin;
                `PSS_ADDR_SMAX: st_d.rdata = st_q.smax;
                `PSS_ADDR_ERR: st_d.rdata = {16'h0000, st_q.err};
                `PSS_ADDR_LOOPEN: st_d.rdata = {24'h00_0000, st_q.loop_en};
                `PSS_ADDR_LOOPIV: st_d.rdata = {24'h00_0000, st_q.loop_iv};
                `PSS_ADDR_RTC: st_d.rdata = st_q.rtc;
                `PSS_ADDR_FILT: st_d.rdata = {12'h000, st_q.fast_byp, st_q.filt};
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
        // peripheral forcing may arrive at any time; logged into image
        if (i_frc_req) begin
            case (i_frc_class)
                PT_IN: st_d.in_img[i_frc_pt] = i_frc_val;
                PT_OUT: st_d.out_img[i_frc_pt] = i_frc_val;
                default: st_d.oth_img[i_frc_pt] = i_frc_val;
            endcase
            st_d.frc_mask[i_frc_pt] = 1'b1;
        end
        case (st_q.seg)
            SEG_INPUT: begin
                for (int k = 0; k < 16; k++) begin
                    if (!st_q.ov_en[pt_idx(PT_IN, 4'(k))]) begin
                        st_d.in_img[k] = filt_in[k];
                    end
                end
                st_d.seg = SEG_PERIPH;
            end
            SEG_PERIPH: begin
                st_d.frc_mask = 16'h0000;
                st_d.seg = SEG_BUS;
            end
            SEG_BUS: begin
                if (!i_bus_req) begin
                    st_d.seg = SEG_CLOCK;
                end
            end
            SEG_CLOCK: begin
                st_d.rtc = st_q.rtc + 32'h0000_0001;
                st_d.clkr = 1'b1;
                st_d.solve_cnt = 32'h0000_0000;
                st_d.seg = st_q.run ? SEG_SOLVE : SEG_OUTPUT;
            end
            SEG_SOLVE: begin
                st_d.solve_cnt = st_q.solve_cnt + 32'h0000_0001;
                if (i_prog_wr && !st_q.ov_en[pt_idx(i_prog_class, i_prog_pt)]) begin
                    if (i_prog_class == PT_OUT) begin
                        st_d.out_img[i_prog_pt] = i_prog_val;
                    end else if (i_prog_class != PT_IN) begin
                        st_d.oth_img[i_prog_pt] = i_prog_val;
                    end
                end
                if (i_imm_out && st_q.run) begin
                    st_d.pins[i_imm_pt] = st_q.out_img[i_imm_pt];
                end
                if (st_q.solve_cnt >= st_q.wdog_lim) begin
                    st_d.fatal = 1'b1;
                    st_d.run = 1'b0;
                    st_d.err = `PSS_ERR_TIMEOUT;
                    st_d.pins = 16'h0000;
                    st_d.seg = SEG_LOOP;
                end else if (i_prog_done) begin
                    st_d.seg = SEG_LOOP;
                end
            end
            SEG_LOOP: begin
                st_d.loop_started = 1'b1;
                if (st_q.loop_started && !loop_busy) begin
                    st_d.loop_started = 1'b0;
                    st_d.seg = SEG_OUTPUT;
                end
            end
            SEG_OUTPUT: begin
                st_d.pins = st_q.run ? st_q.out_img : 16'h0000;
                st_d.seg = SEG_SPEC;
            end
            SEG_SPEC: begin
                st_d.spec = st_q.run;
                st_d.seg = SEG_DIAG;
            end
            SEG_DIAG: begin
                st_d.scur = st_q.scan_cnt;
                st_d.scan_cnt = 32'h0000_0000;
                if (st_q.scan_cnt < st_q.smin || st_q.smin == 32'h0000_0000) begin
                    st_d.smin = st_q.scan_cnt;
                end
                if (st_q.scan_cnt > st_q.smax) begin
                    st_d.smax = st_q.scan_cnt;
                end
                if (st_q.fatal) begin
                    st_d.run = 1'b0;
                    st_d.pins = 16'h0000;
                end
                st_d.seg = SEG_INPUT;
            end
            default: st_d.seg = SEG_INPUT;
        endcase
        if (!st_q.run) begin
            st_d.pins = 16'h0000;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q <= '0;
            st_q.wdog_lim <= 32'(WDOG_CYC);
            st_q.filt <= `PSS_FILT_CYC;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata = st_q.rdata;
    assign o_out_pins = st_q.pins;
    assign o_imm_in_val = live_q2[i_imm_in_pt];
    assign o_in_val = st_q.in_img[i_in_pt];
    assign o_bus_grant = st_q.seg == SEG_BUS && i_bus_req && i_bus_local;
    assign o_spec_strobe = st_q.spec;
    assign o_spec_data = st_q.pins;
    assign o_clk_refresh = st_q.clkr;
    assign o_fatal_err = st_q.fatal;
    assign o_segment = st_q.seg;
    assign o_loop_run = loop_run;
    assign o_solve_en = st_q.seg == SEG_SOLVE;
endmodule // pss_scan_seq

// >>> pss_map.svh
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH
`define PSS_NPTS 16
`define PSS_NLOOPS 8
`define PSS_NFAST 4
`define PSS_WDOG_MS 200
`define PSS_CLK_MHZ 200
`define PSS_WDOG_CYC (`PSS_WDOG_MS * 1000 * `PSS_CLK_MHZ)
`define PSS_ERR_TIMEOUT 16'h0003
`define PSS_FILT_CYC 16'h0010
`define PSS_ADDR_CTRL 8'h00
`define PSS_ADDR_STAT 8'h04
`define PSS_ADDR_WDOG 8'h08
`define PSS_ADDR_SCUR 8'h0C
`define PSS_ADDR_SMIN 8'h10
`define PSS_ADDR_SMAX 8'h14
`define PSS_ADDR_ERR 8'h18
`define PSS_ADDR_OVEN 8'h1C
`define PSS_ADDR_LOOPEN 8'h20
`define PSS_ADDR_LOOPIV 8'h24
`define PSS_ADDR_RTC 8'h28
`define PSS_ADDR_FILT 8'h2C
`define PSS_CTRL_RUN 0
`define PSS_STAT_FATAL 1
`endif

// >>> pss_pkg.sv
package pss_pkg;
    typedef enum logic [3:0] {
        SEG_INPUT = 4'b0000,
        SEG_PERIPH = 4'b0001,
        SEG_BUS = 4'b0010,
        SEG_CLOCK = 4'b0011,
        SEG_SOLVE = 4'b0100,
        SEG_LOOP = 4'b0101,
        SEG_OUTPUT = 4'b0110,
        SEG_SPEC = 4'b0111,
        SEG_DIAG = 4'b1000
    } pss_seg_t;
    typedef enum logic [1:0] {
        PT_IN = 2'b00,
        PT_OUT = 2'b01,
        PT_OTHER = 2'b10
    } pss_pt_class_t;
endpackage

// >>> pss_in_filter.sv
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_in_filter
    import pss_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_raw,
    input wire logic i_bypass,
    input wire logic [15:0] i_len,
    output logic o_val
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic val;
        logic [15:0] cnt;
    } pss_filt_t;
    pss_filt_t st_q, st_d;
    always_comb begin
        st_d = st_q;
        st_d.s1 = i_raw;
        st_d.s2 = st_q.s1;
        if (i_bypass || i_len == 16'h0000) begin
            st_d.val = st_q.s2;
            st_d.cnt = 16'h0000;
        end else if (st_q.s2 == st_q.val) begin
            st_d.cnt = 16'h0000;
        end else if (st_q.cnt >= i_len - 16'h0001) begin
            st_d.val = st_q.s2;
            st_d.cnt = 16'h0000;
        end else begin
            st_d.cnt = st_q.cnt + 16'h0001;
        end
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign o_val = st_q.val;
endmodule // pss_in_filter

// >>> pss_loop_sched.sv
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_loop_sched
    import pss_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic [7:0] i_loop_en,
    input wire logic [7:0] i_interval,
    output logic o_busy,
    output logic [7:0] o_loop_run
);
    // one step per loop; each loop keeps its own down-counter in scans
    typedef struct packed {
        logic busy;
        logic [2:0] idx;
        logic [7:0] run;
        logic [63:0] cnt;
    } pss_sched_t;
    pss_sched_t st_q, st_d;
    logic [7:0] c;
    always_comb begin
        st_d = st_q;
        c = 8'h00;
        if (i_start && !st_q.busy) begin
            st_d.busy = 1'b1;
            st_d.idx = 3'h0;
            st_d.run = 8'h00;
        end else if (st_q.busy) begin
            c = st_q.cnt[st_q.idx*8 +: 8];
            if (i_loop_en[st_q.idx]) begin
                if (c == 8'h00) begin
                    st_d.run[st_q.idx] = 1'b1;
                    st_d.cnt[st_q.idx*8 +: 8] = i_interval;
                end else begin
                    st_d.cnt[st_q.idx*8 +: 8] = c - 8'h01;
                end
            end
            if (st_q.idx == 3'h7) begin
                st_d.busy = 1'b0;
            end
            st_d.idx = st_q.idx + 3'h1;
        end
    end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign o_busy = st_q.busy;
    assign o_loop_run = st_q.run;
endmodule // pss_loop_sched

// >>> pss_scan_checker.sv
`timescale 1ns/1ps
module pss_scan_checker
    import pss_pkg::*;
#(
    parameter int WDOG_CYC = 200
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_bus_req,
    input wire logic i_bus_local,
    input wire logic i_imm_out,
    input wire logic [3:0] o_segment,
    input wire logic o_solve_en,
    input wire logic o_fatal_err,
    input wire logic o_bus_grant,
    input wire logic o_spec_strobe,
    input wire logic [15:0] o_spec_data,
    input wire logic [15:0] o_out_pins,
    input wire logic o_clk_refresh
);
    int solve_cyc_q;
    // counter, since a long repetition would choke the tools
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            solve_cyc_q <= 0;
        end else begin
            solve_cyc_q <= (o_segment == SEG_SOLVE) ? solve_cyc_q + 1 : 0;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    a_seg_order: assert property ($changed(o_segment) |->
        o_segment == (($past(o_segment) == 4'h8) ? 4'h0 : $past(o_segment) + 4'h1)
        || ($past(o_segment) == SEG_CLOCK && o_segment == SEG_OUTPUT)) else $error("segment order broken");
    a_solve_gate: assert property (o_solve_en |-> o_segment == SEG_SOLVE && !o_fatal_err)
        else $error("solve outside its segment");
    a_bus_local: assert property (o_bus_grant |-> i_bus_req && i_bus_local && o_segment == SEG_BUS)
        else $error("bus grant off local base");
    a_spec_data: assert property (o_spec_strobe |-> o_segment == SEG_DIAG && o_spec_data == o_out_pins)
        else $error("module data differs from pins");
    a_clk_pulse: assert property ($changed(o_segment) && o_segment == SEG_CLOCK |-> ##[0:2] o_clk_refresh)
        else $error("no clock refresh");
    a_fatal_off: assert property (o_fatal_err && $past(o_fatal_err) |-> o_out_pins == 16'h0000)
        else $error("outputs on while fatal");
    a_out_moment: assert property ($changed(o_out_pins) |-> o_out_pins == 16'h0000
        || $past(o_segment) inside {SEG_OUTPUT, SEG_SPEC} || $past(i_imm_out) || $past(i_imm_out, 2))
        else $error("outputs changed off segment");
    a_solve_bound: assert property (solve_cyc_q <= WDOG_CYC + 2)
        else $error("solve overran watchdog");
endmodule // pss_scan_checker

// >>> pss_periph_model.sv
`timescale 1ns/1ps
module pss_periph_model
    import pss_pkg::*;
(
    input wire logic i_clk,
    input wire logic [3:0] i_segment,
    input wire logic i_bus_grant,
    output logic o_frc_req,
    output logic [1:0] o_frc_class,
    output logic [3:0] o_frc_pt,
    output logic o_frc_val,
    output logic o_bus_req,
    output logic o_bus_local
);
    logic grant_seen;
    initial begin
        o_frc_req = 1'h0;
        o_frc_class = 2'h3;
        o_frc_pt = 4'h0;
        o_frc_val = 1'h0;
        o_bus_req = 1'h0;
        o_bus_local = 1'h0;
        grant_seen = 1'h0;
    end
    // fields flip after the pulse so nothing stale looks valid
    task automatic force_pt(input logic [1:0] cls, input logic [3:0] pt, input logic val);
        @(posedge i_clk);
        o_frc_req <= 1'h1;
        o_frc_class <= cls;
        o_frc_pt <= pt;
        o_frc_val <= val;
        @(posedge i_clk);
        o_frc_req <= 1'h0;
        o_frc_class <= ~cls;
        o_frc_pt <= ~pt;
        o_frc_val <= ~val;
    endtask
    task automatic bus_xfer(input logic local_base);
        int n;
        int m;
        n = 0;
        m = 0;
        grant_seen = 1'h0;
        while (i_segment !== SEG_PERIPH && m < 4000) begin
            @(posedge i_clk);
            #1;
            m++;
        end
        o_bus_req <= 1'h1;
        o_bus_local <= local_base;
        while (n < 4 && m < 8000) begin
            @(posedge i_clk);
            #1;
            m++;
            if (i_segment === SEG_BUS) n++;
            if (i_bus_grant === 1'h1) grant_seen = 1'h1;
        end
        o_bus_req <= 1'h0;
        o_bus_local <= ~local_base;
    endtask
endmodule // pss_periph_model

// >>> pss_scan_seq_test.sv
`timescale 1ns/1ps
`include "pss_map.svh"
module pss_scan_seq_test
    import pss_pkg::*;
;
    localparam int WDOG_CYC = 200;
    logic i_clk, i_sys_rst, i_wr, i_rd, i_prog_done, i_prog_wr, i_prog_val, i_imm_out;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [15:0] i_in_pins, o_out_pins, o_spec_data;
    logic [1:0] i_prog_class, frc_class;
    logic [3:0] i_prog_pt, i_imm_pt, i_imm_in_pt, i_in_pt, frc_pt, o_segment;
    logic [7:0] o_loop_run;
    logic frc_req, frc_val, bus_req, bus_local, o_bus_grant, o_imm_in_val, o_in_val;
    logic o_spec_strobe, o_clk_refresh, o_fatal_err, o_solve_en, pw_en, imm_en, auto_done;
    int scnt, fail_count, n_compared;
    pss_scan_seq #(.WDOG_CYC(WDOG_CYC)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_in_pins(i_in_pins),
        .o_out_pins(o_out_pins), .i_frc_req(frc_req), .i_frc_class(frc_class), .i_frc_pt(frc_pt),
        .i_frc_val(frc_val), .i_prog_done(i_prog_done), .i_prog_wr(i_prog_wr), .i_prog_class(i_prog_class),
        .i_prog_pt(i_prog_pt), .i_prog_val(i_prog_val), .i_imm_out(i_imm_out), .i_imm_pt(i_imm_pt),
        .i_imm_in_pt(i_imm_in_pt), .o_imm_in_val(o_imm_in_val), .i_in_pt(i_in_pt), .o_in_val(o_in_val),
        .i_bus_req(bus_req), .i_bus_local(bus_local), .o_bus_grant(o_bus_grant), .o_spec_strobe(o_spec_strobe),
        .o_spec_data(o_spec_data), .o_clk_refresh(o_clk_refresh), .o_fatal_err(o_fatal_err),
        .o_segment(o_segment), .o_loop_run(o_loop_run), .o_solve_en(o_solve_en));
    pss_periph_model peri (.i_clk(i_clk), .i_segment(o_segment), .i_bus_grant(o_bus_grant), .o_frc_req(frc_req),
        .o_frc_class(frc_class), .o_frc_pt(frc_pt), .o_frc_val(frc_val), .o_bus_req(bus_req),
        .o_bus_local(bus_local));
    always #2.5 i_clk = ~i_clk;
    // stands in for the user program: one write, optional immediate out, then done
    always @(posedge i_clk) begin
        scnt <= (o_segment === SEG_SOLVE) ? scnt + 1 : 0;
        i_prog_wr <= pw_en && scnt == 1;
        i_imm_out <= imm_en && scnt == 3;
        i_prog_done <= auto_done && scnt == 6;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'h1;
        @(posedge i_clk);
        i_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'h1;
        @(posedge i_clk);
        i_rd <= 1'h0;
        #1;
        check(o_rdata, exp);
    endtask
    // waits for entry into a segment, not mere presence
    task automatic wait_seg(input logic [3:0] s);
        int n;
        n = 0;
        while (o_segment === s && n < 3000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        while (o_segment !== s && n < 3000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n >= 3000) check(32'h0000_0000, 32'h0000_0001);
    endtask
    task automatic scans(input int k);
        repeat (k) wait_seg(SEG_DIAG);
    endtask
    task automatic wrap_up;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end
    initial begin
        logic [7:0] acc;
        int n;
        {i_clk, i_wr, i_rd, i_prog_done, i_prog_wr, i_prog_val, i_imm_out, pw_en, imm_en, auto_done} = '0;
        {i_addr, i_wdata, i_in_pins, i_prog_class, i_prog_pt, i_imm_pt, i_imm_in_pt, i_in_pt} = '0;
        {scnt, fail_count, n_compared} = '0;
        i_sys_rst = 1'h1;
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'h0;
        #1;
        check(o_out_pins, 32'h0000_0000);
        rd(`PSS_ADDR_WDOG, WDOG_CYC);
        rd(`PSS_ADDR_ERR, 32'h0000_0000);
        rd(8'h30, 32'h0000_0000);
        i_in_pins <= 16'h0001;
        scans(4);
        check(o_in_val, 32'h0000_0001);
        check(o_out_pins, 32'h0000_0000);
        $display("test program mode done");
        wr(`PSS_ADDR_FILT, 32'h000F_0004);
        auto_done = 1'h1;
        wr(`PSS_ADDR_CTRL, 32'h0000_0001);
        wait_seg(SEG_DIAG);
        {i_prog_class, i_prog_pt, i_prog_val} <= {PT_OUT, 4'h3, 1'h1};
        pw_en = 1'h1;
        wait_seg(SEG_LOOP);
        check(o_out_pins[3], 32'h0000_0000);
        wait_seg(SEG_SPEC);
        check(o_out_pins[3], 32'h0000_0001);
        i_prog_pt <= 4'h5;
        i_imm_pt <= 4'h5;
        imm_en = 1'h1;
        wait_seg(SEG_LOOP);
        check(o_out_pins[5], 32'h0000_0001);
        {pw_en, imm_en} = 2'h0;
        $display("test outputs done");
        wait_seg(SEG_PERIPH);
        i_in_pins <= 16'h0003;
        {i_in_pt, i_imm_in_pt} <= 8'h11;
        wait_seg(SEG_SOLVE);
        repeat (3) @(posedge i_clk);
        #1;
        check({o_in_val, o_imm_in_val}, 32'h0000_0001);
        wait_seg(SEG_SOLVE);
        check(o_in_val, 32'h0000_0001);
        i_in_pt <= 4'h7;
        peri.force_pt(PT_IN, 4'h7, 1'h1);
        #1;
        check(o_in_val, 32'h0000_0001);
        wait_seg(SEG_SOLVE);
        check(o_in_val, 32'h0000_0000);
        wr(`PSS_ADDR_OVEN, 32'h0002_0001);
        i_in_pt <= 4'h2;
        i_in_pins <= 16'h0007;
        scans(3);
        check(o_in_val, 32'h0000_0000);
        peri.force_pt(PT_IN, 4'h2, 1'h1);
        scans(3);
        check(o_in_val, 32'h0000_0001);
        $display("test forcing done");
        peri.bus_xfer(1'h1);
        check(peri.grant_seen, 32'h0000_0001);
        peri.bus_xfer(1'h0);
        check(peri.grant_seen, 32'h0000_0000);
        wr(`PSS_ADDR_LOOPEN, 32'h0000_0005);
        wr(`PSS_ADDR_LOOPIV, 32'h0000_0001);
        scans(1);
        acc = 8'h00;
        repeat (4) begin
            wait_seg(SEG_OUTPUT);
            acc = acc | o_loop_run;
        end
        check(acc, 32'h0000_0005);
        $display("test bus and loops done");
        wr(`PSS_ADDR_WDOG, WDOG_CYC + 1);
        rd(`PSS_ADDR_WDOG, WDOG_CYC + 1);
        auto_done = 1'h0;
        n = 0;
        while (o_fatal_err !== 1'h1 && n < 3000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        repeat (2) @(posedge i_clk);
        #1;
        check({o_fatal_err, o_out_pins}, 32'h0001_0000);
        rd(`PSS_ADDR_ERR, `PSS_ERR_TIMEOUT);
        // segment field keeps moving, so only fatal and run are compared
        @(posedge i_clk);
        i_addr <= `PSS_ADDR_STAT;
        i_rd <= 1'h1;
        @(posedge i_clk);
        i_rd <= 1'h0;
        #1;
        check(o_rdata & 32'h0000_001F, 32'h0000_0002);
        $display("test watchdog done");
        wrap_up();
    end
endmodule // pss_scan_seq_test
bind pss_scan_seq pss_scan_checker #(.WDOG_CYC(WDOG_CYC)) u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_bus_req(i_bus_req), .i_bus_local(i_bus_local), .i_imm_out(i_imm_out), .o_segment(o_segment),
    .o_solve_en(o_solve_en), .o_fatal_err(o_fatal_err), .o_bus_grant(o_bus_grant), .o_spec_strobe(o_spec_strobe),
    .o_spec_data(o_spec_data), .o_out_pins(o_out_pins), .o_clk_refresh(o_clk_refresh));
